// [dv/adb_axi_mem.sv]
// axi slave memory model standing in for the dram controller
// assumes one burst at a time, 64 words, address and read delay set by stall
`timescale 1ns/100ps
module adb_axi_mem
  import adb_pkg::*;
(
  input wire logic ref_clk,
  input wire adb_axi_out_t axiOut,
  output adb_axi_in_t axiIn,
  input wire logic [1:0] stall
);
  logic [31:0] mem [64];
  logic [3:0] base;
  int k;
  // known contents so that a miss has a checkable value; one process owns mem and axiIn
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 32'ha5a5_0000 + i;
    axiIn = '0;
    // address, beats, then response; released read data is scrambled
    forever begin
      @(posedge ref_clk);
      if (axiOut.awvalid) begin
        repeat (stall) @(posedge ref_clk);
        axiIn.awready <= 1'b1;
        @(posedge ref_clk);
        axiIn.awready <= 1'b0;
        axiIn.wready <= 1'b1;
        base = axiOut.awaddr[7:4];
        for (k = 0; k < 4;) begin
          @(posedge ref_clk);
          if (axiOut.wvalid) begin
            for (int b = 0; b < 4; b++) if (axiOut.wstrb[b]) mem[{base, k[1:0]}][8*b+:8] = axiOut.wdata[8*b+:8];
            k++;
          end
        end
        axiIn.wready <= 1'b0;
        axiIn.bvalid <= 1'b1;
        do @(posedge ref_clk); while (!axiOut.bready);
        axiIn.bvalid <= 1'b0;
      end else if (axiOut.arvalid) begin
        repeat (stall) @(posedge ref_clk);
        axiIn.arready <= 1'b1;
        @(posedge ref_clk);
        axiIn.arready <= 1'b0;
        base = axiOut.araddr[7:4];
        for (k = 0; k < 4; k++) begin
          repeat (stall) @(posedge ref_clk);
          axiIn.rvalid <= 1'b1;
          axiIn.rlast <= (k == 3);
          axiIn.rdata <= mem[{base, k[1:0]}];
          do @(posedge ref_clk); while (!axiOut.rready);
          // lowering between back-to-back beats would double-drive the step
          if (stall != 2'h0 || k == 3) begin
            axiIn.rvalid <= 1'b0;
            axiIn.rdata <= ~mem[{base, k[1:0]}];
          end
        end
        axiIn.rlast <= 1'b0;
      end
    end
  end
endmodule

// [dv/adb_combining_bridge_bench.sv]
// self-checking bench for the combining bridge and an axi memory model
// assumes bridge and model share ref_clk; port 3 plays the word-only dma master
`timescale 1ns/100ps
module adb_combining_bridge_bench
  import adb_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst;
  logic [1:0] stall;
  adb_ahb_req_t drv [NUM_PORTS];
  adb_ahb_req_t ahbReq [NUM_PORTS];
  adb_ahb_rsp_t ahbRsp [NUM_PORTS];
  adb_axi_out_t axiOut;
  adb_axi_in_t axiIn;
  logic [31:0] refMem [64];
  logic [31:0] seed;
  logic [31:0] r;
  int n_fail, tests_run, nAr, nAw, nW, k;
  always #50 ref_clk = ~ref_clk;
  // bus hready follows each port's own hreadyout
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      ahbReq[i] = drv[i];
      ahbReq[i].hready = ahbRsp[i].hreadyout;
    end
  end
  adb_combining_bridge dut_u (.ref_clk(ref_clk), .rst(rst), .ahbReq(ahbReq), .ahbRsp(ahbRsp), .axiOut(axiOut),
    .axiIn(axiIn));
  adb_axi_mem mem_u (.ref_clk(ref_clk), .axiOut(axiOut), .axiIn(axiIn), .stall(stall));
  // axi handshake counts show bursts and skipped fetches
  always @(posedge ref_clk) begin
    if (axiOut.arvalid && axiIn.arready) nAr++;
    if (axiOut.awvalid && axiIn.awready) nAw++;
    if (axiOut.wvalid && axiIn.wready) nW++;
  end
  task automatic check(logic ok, string m);
    tests_run++;
    // an unknown outcome counts as a mismatch
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] d, logic [2:0] sz, logic [1:0] a);
    logic [3:0] m;
    m = (sz == HSIZE_BYTE) ? 4'h1 << a : (sz == HSIZE_HALF) ? 4'h3 << {a[1], 1'b0} : 4'hf;
    for (int b = 0; b < 4; b++) if (m[b]) o[8*b+:8] = d[8*b+:8];
    return o;
  endfunction
  // one ahb transfer, answer checked against the reference image
  task automatic xfer(int p, logic [31:0] a, logic w, logic [2:0] sz, logic [31:0] d);
    logic [31:0] exp;
    int n;
    exp = refMem[a[7:2]];
    if (w) refMem[a[7:2]] = merge(exp, d, sz, a[1:0]);
    drv[p].hsel = 1'b1;
    drv[p].htrans = 2'h2;
    drv[p].haddr = a;
    drv[p].hwrite = w;
    drv[p].hsize = sz;
    @(posedge ref_clk);
    @(negedge ref_clk);
    drv[p].hsel = 1'b0;
    drv[p].htrans = 2'h0;
    drv[p].hwdata = d;
    for (n = 0; n < 400 && ahbRsp[p].hreadyout !== 1'b1; n++) @(negedge ref_clk);
    check(n < 400 && (w || ahbRsp[p].hrdata === exp), "ahb answer");
    @(negedge ref_clk);
  endtask
  task automatic rand_op(int p, logic [7:0] msk, logic [7:0] set);
    logic [31:0] q;
    logic [31:0] a;
    logic [2:0] sz;
    q = $random(seed);
    sz = (p == 3) ? 3'h2 : 3'(q[9:8] % 2'h3);
    a = {24'h00_0000, (q[7:0] & msk) | set};
    if (sz == 3'h2) a[1:0] = 2'h0;
    if (sz == 3'h1) a[0] = 1'b0;
    xfer(p, a, q[12], sz, $random(seed));
  endtask
  task automatic conclude;
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // cut a hang short well past the expected run length
  initial begin
    #5_000_000;
    check(1'b0, "watchdog");
    conclude;
  end
  initial begin
    seed = 32'h0000_c4b2;
    rst = 1'b1;
    stall = 2'h0;
    n_fail = 0;
    tests_run = 0;
    nAr = 0;
    nAw = 0;
    nW = 0;
    for (int i = 0; i < NUM_PORTS; i++) drv[i] = '0;
    for (int i = 0; i < 64; i++) refMem[i] = 32'ha5a5_0000 + i;
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    check(ahbRsp[0].hreadyout === 1'b1 && axiOut.awvalid === 1'b0 && axiOut.arvalid === 1'b0, "reset");
    // a second port reading a fetched line must not fetch again
    xfer(0, 32'h0000_0040, 1'b0, 3'h2, 32'h0000_0000);
    k = nAr;
    xfer(1, 32'h0000_0044, 1'b0, 3'h2, 32'h0000_0000);
    check(nAr == k, "hit fetched again");
    // byte write into the fetched line, word read from another port
    xfer(2, 32'h0000_0049, 1'b1, HSIZE_BYTE, 32'h0000_5a00);
    xfer(3, 32'h0000_0048, 1'b0, 3'h2, 32'h0000_0000);
    // five lines in a row, each written back at idle before the next write is served
    for (int i = 0; i < 5; i++) xfer(i % 3, 32'h0000_0080 + 32'(16 * i), 1'b1, 3'h2, $random(seed));
    for (int i = 0; i < 5; i++) xfer(3, 32'h0000_0080 + 32'(16 * i), 1'b0, 3'h2, 32'h0000_0000);
    // random traffic, one port at a time, memory speed varying
    repeat (200) begin
      r = $random(seed);
      stall = r[1:0];
      rand_op(r[5:4], 8'hff, 8'h00);
    end
    // all four ports at once on their own lines, so the arbiter is loaded
    stall = 2'h1;
    for (int p = 0; p < NUM_PORTS; p++) begin
      fork
        automatic int q = p;
        repeat (20) rand_op(q, 8'hcf, 8'(q << 4));
      join_none
    end
    wait fork;
    repeat (100) @(negedge ref_clk);
    check(nW == 4 * nAw && nAw > 0, "burst beat count");
    for (int i = 0; i < 64; i++) check(mem_u.mem[i] === refMem[i], "memory after flush");
    conclude;
  end
endmodule

// [dv/adb_monitor.sv]
// port checker for the ahb-to-axi combining bridge
// assumes it is bound onto the bridge top module and sees only its ports
`timescale 1ns/100ps
module adb_monitor
  import adb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire adb_ahb_req_t ahbReq [NUM_PORTS],
  input wire adb_ahb_rsp_t ahbRsp [NUM_PORTS],
  input wire adb_axi_out_t axiOut,
  input wire adb_axi_in_t axiIn
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // burst shape, alignment and holding of axi requests
  a_aw_burst_shape: assert property (
    axiOut.awvalid |-> axiOut.awlen == AXI_LEN_LINE && axiOut.awsize == AXI_SIZE_WORD
      && axiOut.awburst == AXI_BURST_INCR && axiOut.awaddr[3:0] == LINE_OFS) else $error("bad write burst");
  a_ar_burst_shape: assert property (
    axiOut.arvalid |-> axiOut.arlen == AXI_LEN_LINE && axiOut.arsize == AXI_SIZE_WORD
      && axiOut.arburst == AXI_BURST_INCR && axiOut.araddr[3:0] == LINE_OFS) else $error("bad read burst");
  a_aw_held: assert property (
    axiOut.awvalid && !axiIn.awready |=> axiOut.awvalid && $stable(axiOut.awaddr)) else $error("aw dropped");
  a_ar_held: assert property (
    axiOut.arvalid && !axiIn.arready |=> axiOut.arvalid && $stable(axiOut.araddr)) else $error("ar dropped");
  a_one_burst: assert property (
    !(axiOut.awvalid && axiOut.arvalid) && !(axiOut.wvalid && axiOut.arvalid)) else $error("bursts overlap");
  a_w_follows_aw: assert property (
    axiOut.awvalid && axiIn.awready |=> axiOut.wvalid) else $error("no data after aw");
  a_b_after_last: assert property (
    axiOut.wvalid && axiIn.wready && axiOut.wlast |=> axiOut.bready && !axiOut.wvalid) else $error("no bready");
  a_r_follows_ar: assert property (
    axiOut.arvalid && axiIn.arready |=> axiOut.rready && !axiOut.arvalid) else $error("no rready");
  a_resp_okay: assert property (
    ahbRsp[0].hresp == HRESP_OKAY && ahbRsp[1].hresp == HRESP_OKAY && ahbRsp[2].hresp == HRESP_OKAY
      && ahbRsp[3].hresp == HRESP_OKAY) else $error("error response");
  // every taken transfer stalls at least two cycles
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    a_min_stall: assert property (
      ahbReq[p].hsel && ahbReq[p].htrans[HTRANS_ACTIVE_BIT] && ahbReq[p].hready |=> (!ahbRsp[p].hreadyout) [*2])
      else $error("answer too early");
  end
endmodule
bind adb_combining_bridge adb_monitor mon_u (.ref_clk(ref_clk), .rst(rst), .ahbReq(ahbReq), .ahbRsp(ahbRsp),
  .axiOut(axiOut), .axiIn(axiIn));

// [rtl/adb_combining_bridge.sv]
// four-port ahb-lite to single axi master bridge with write/read combining line buffers
// assumes all ports and the axi slave share ref_clk; one transfer per port outstanding
`timescale 1ns/100ps
module adb_combining_bridge
  import adb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire adb_ahb_req_t ahbReq [NUM_PORTS],
  output adb_ahb_rsp_t ahbRsp [NUM_PORTS],
  output adb_axi_out_t axiOut,
  input wire adb_axi_in_t axiIn
);

  // lowest set bit of a four-bit vector
  function automatic logic [1:0] firstIdx(input logic [3:0] v);
    logic [1:0] r;
    r = 2'h0;
    for (int k = 3; k >= 0; k--) begin
      if (v[k]) begin
        r = 2'(k);
      end
    end
    return r;
  endfunction

  // next requester after the last granted one
  function automatic logic [1:0] rrPick(input logic [3:0] v, input logic [1:0] last);
    logic [1:0] r;
    logic [1:0] idx;
    logic found;
    r = last;
    found = 1'b0;
    for (int k = 1; k <= 4; k++) begin
      idx = 2'(last + 2'(k));
      if (v[idx] && !found) begin
        r = idx;
        found = 1'b1;
      end
    end
    return r;
  endfunction

  // byte lanes of one ahb beat
  function automatic logic [3:0] laneMask(input logic [2:0] size, input logic [1:0] ofs);
    logic [3:0] m;
    m = 4'hF;
    if (size == HSIZE_BYTE) begin
      m = 4'(4'h1 << ofs);
    end else if (size == HSIZE_HALF) begin
      m = ofs[1] ? 4'hC : 4'h3;
    end
    return m;
  endfunction

  // byte merge of new data over old
  function automatic logic [31:0] mergeWord(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int k = 0; k < 4; k++) begin
      if (be[k]) begin
        r[k*8 +: 8] = nw[k*8 +: 8];
      end
    end
    return r;
  endfunction

  adb_state_t state_ff, nxt_state;
  logic [1:0] curPort_ff, nxt_curPort;
  logic [1:0] rrLast_ff;
  logic [1:0] flushSel_ff, nxt_flushSel;
  logic flushBack_ff, nxt_flushBack;
  logic [1:0] beat_ff;
  logic [1:0] victim_ff;
  logic [3:0] pend_ff;
  logic [3:0] resp_ff;
  logic [31:0] pAddr_ff [NUM_PORTS];
  logic pWrite_ff [NUM_PORTS];
  logic [2:0] pSize_ff [NUM_PORTS];
  logic [31:0] hrdata_ff [NUM_PORTS];
  adb_tag_t bufTag_ff [NUM_BUFS];
  logic bufValid_ff [NUM_BUFS];
  logic bufFull_ff [NUM_BUFS];
  logic bufDirty_ff [NUM_BUFS];
  logic [31:0] bufData_ff [NUM_BUFS][LINE_WORDS];
  logic [3:0] bufMask_ff [NUM_BUFS][LINE_WORDS];
  logic [3:0] tagHit, fullHit, dirtyVec, mergeEn, allocEn, flushDone;

  // decode of the granted request
  wire logic [31:0] curAddr = pAddr_ff[curPort_ff];
  wire logic curWrite = pWrite_ff[curPort_ff];
  wire adb_tag_t curTag = curAddr[31:4];
  wire logic [1:0] curWord = curAddr[3:2];
  wire logic [31:0] curWdata = ahbReq[curPort_ff].hwdata;
  // the dma port only issues words; lane mask still honours hsize for the others
  wire logic [3:0] curBe = laneMask(pSize_ff[curPort_ff], curAddr[1:0]);
  wire logic inLook = (state_ff == ST_LOOK);
  wire logic [3:0] reqVec = pend_ff & ~resp_ff;
  wire logic [2:0] tagHitW = tagHit[2:0];
  wire logic [2:0] dirtyW = dirtyVec[2:0];
  wire logic wrMatch = |tagHitW;
  wire logic [1:0] wrMatchIdx = firstIdx({1'b0, tagHitW});
  wire logic anyFree = ~&dirtyW;
  wire logic [1:0] freeIdx = firstIdx({1'b0, ~dirtyW});
  wire logic [1:0] wrIdx = wrMatch ? wrMatchIdx : freeIdx;
  wire logic wrTgt = inLook && curWrite && (wrMatch || anyFree);
  wire logic readHit = |fullHit;
  wire logic [1:0] hitIdx = firstIdx(fullHit);
  wire logic [31:0] hitWord = bufData_ff[hitIdx][curWord];
  wire logic finish = wrTgt || (inLook && !curWrite && readHit);
  // miss with no write buffer holding the line: refill the read-only buffer
  wire logic missEn = inLook && !curWrite && !readHit && !wrMatch;
  wire logic fillEn = (state_ff == ST_RDR) && axiIn.rvalid;
  wire logic fillDone = fillEn && axiIn.rlast;

  // per-buffer state; buffers 0..2 combine writes, buffer 3 only ever fills from reads
  for (genvar b = 0; b < NUM_BUFS; b++) begin : g_buf
    assign tagHit[b] = bufValid_ff[b] && (bufTag_ff[b] == curTag);
    assign fullHit[b] = tagHit[b] && bufFull_ff[b];
    assign dirtyVec[b] = bufDirty_ff[b];
    assign allocEn[b] = (b < NUM_WR_BUFS) && wrTgt && !wrMatch && (wrIdx == 2'(b));
    // writes also patch a full read copy so later hits stay current
    assign mergeEn[b] = wrTgt && ((b < NUM_WR_BUFS) ? (wrIdx == 2'(b)) : fullHit[b]);
    assign flushDone[b] = (state_ff == ST_FLB) && axiIn.bvalid && (flushSel_ff == 2'(b));

    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        bufTag_ff[b] <= TAG_RST;
        bufValid_ff[b] <= 1'b0;
        bufFull_ff[b] <= 1'b0;
        bufDirty_ff[b] <= 1'b0;
      end else if (allocEn[b]) begin
        bufTag_ff[b] <= curTag;
        bufValid_ff[b] <= 1'b1;
        bufFull_ff[b] <= 1'b0;
        bufDirty_ff[b] <= 1'b1;
      end else if (b == RD_BUF && missEn) begin
        bufValid_ff[b] <= 1'b0;
      end else if (b == RD_BUF && fillDone) begin
        bufTag_ff[b] <= curTag;
        bufValid_ff[b] <= 1'b1;
        bufFull_ff[b] <= 1'b1;
      end else if (flushDone[b]) begin
        bufDirty_ff[b] <= 1'b0;
        bufValid_ff[b] <= bufFull_ff[b]; // partial lines hold nothing useful once written out
      end else if (mergeEn[b] && b < NUM_WR_BUFS) begin
        bufDirty_ff[b] <= 1'b1;
      end
    end

    // line words and their written-byte masks
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        for (int w = 0; w < LINE_WORDS; w++) begin
          bufData_ff[b][w] <= DATA_RST;
          bufMask_ff[b][w] <= MASK_RST;
        end
      end else begin
        for (int w = 0; w < LINE_WORDS; w++) begin
          if (mergeEn[b] && curWord == 2'(w)) begin
            bufData_ff[b][w] <= mergeWord(bufData_ff[b][w], curWdata, curBe);
            bufMask_ff[b][w] <= (allocEn[b] ? MASK_RST : bufMask_ff[b][w]) | curBe;
          end else if (allocEn[b] || flushDone[b]) begin
            bufMask_ff[b][w] <= MASK_RST;
          end else if (b == RD_BUF && fillEn && beat_ff == 2'(w)) begin
            bufData_ff[b][w] <= axiIn.rdata;
          end
        end
      end
    end
  end

  // ahb slave ports: one pending transfer each, stalled until the engine answers
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    wire logic take = ahbReq[p].hsel && ahbReq[p].htrans[HTRANS_ACTIVE_BIT] && ahbReq[p].hready;
    assign ahbRsp[p].hreadyout = !pend_ff[p] || resp_ff[p];
    assign ahbRsp[p].hresp = HRESP_OKAY;
    assign ahbRsp[p].hrdata = hrdata_ff[p];

    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        pend_ff[p] <= 1'b0;
        resp_ff[p] <= 1'b0;
        pAddr_ff[p] <= DATA_RST;
        pWrite_ff[p] <= 1'b0;
        pSize_ff[p] <= HSIZE_BYTE;
        hrdata_ff[p] <= DATA_RST;
      end else begin
        pend_ff[p] <= take || (pend_ff[p] && !resp_ff[p]); // new address phase wins over completion
        resp_ff[p] <= finish && (curPort_ff == 2'(p));
        if (take) begin
          pAddr_ff[p] <= ahbReq[p].haddr;
          pWrite_ff[p] <= ahbReq[p].hwrite;
          pSize_ff[p] <= ahbReq[p].hsize;
        end
        if (finish && !curWrite && curPort_ff == 2'(p)) begin
          hrdata_ff[p] <= hitWord;
        end
      end
    end
  end

  // engine sequencing: serve one request, flush on eviction, coherence or idle
  always_comb begin
    nxt_state = state_ff;
    nxt_curPort = curPort_ff;
    nxt_flushSel = flushSel_ff;
    nxt_flushBack = flushBack_ff;
    case (state_ff)
      ST_IDLE: begin
        if (|reqVec) begin
          nxt_curPort = rrPick(reqVec, rrLast_ff);
          nxt_state = ST_LOOK;
        end else if (|dirtyW) begin
          nxt_flushSel = firstIdx({1'b0, dirtyW});
          nxt_flushBack = 1'b0;
          nxt_state = ST_FLAW;
        end
      end
      ST_LOOK: begin
        if (finish) begin
          nxt_state = ST_IDLE;
        end else if (curWrite) begin
          nxt_flushSel = victim_ff;
          nxt_flushBack = 1'b1;
          nxt_state = ST_FLAW;
        end else if (wrMatch) begin
          nxt_flushSel = wrMatchIdx;
          nxt_flushBack = 1'b1;
          nxt_state = ST_FLAW;
        end else begin
          nxt_state = ST_RDAR;
        end
      end
      ST_FLAW: nxt_state = axiIn.awready ? ST_FLW : ST_FLAW;
      ST_FLW: nxt_state = (axiIn.wready && beat_ff == LAST_BEAT) ? ST_FLB : ST_FLW;
      ST_FLB: begin
        if (axiIn.bvalid) begin
          nxt_state = flushBack_ff ? ST_LOOK : ST_IDLE;
        end
      end
      ST_RDAR: nxt_state = axiIn.arready ? ST_RDR : ST_RDAR;
      ST_RDR: nxt_state = fillDone ? ST_LOOK : ST_RDR;
      default: nxt_state = ST_IDLE;
    endcase
  end

  // engine registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      curPort_ff <= IDX_RST;
      rrLast_ff <= 2'h3;
      flushSel_ff <= IDX_RST;
      flushBack_ff <= 1'b0;
      victim_ff <= IDX_RST;
    end else begin
      state_ff <= nxt_state;
      curPort_ff <= nxt_curPort;
      flushSel_ff <= nxt_flushSel;
      flushBack_ff <= nxt_flushBack;
      if (state_ff == ST_IDLE && |reqVec) begin
        rrLast_ff <= nxt_curPort;
      end
      if (inLook && curWrite && !finish) begin
        victim_ff <= (victim_ff == 2'(NUM_WR_BUFS - 1)) ? IDX_RST : 2'(victim_ff + 2'h1);
      end
    end
  end

  // beat counter shared by flush and refill bursts
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      beat_ff <= IDX_RST;
    end else if (state_ff == ST_FLAW || state_ff == ST_RDAR) begin
      beat_ff <= IDX_RST;
    end else if ((state_ff == ST_FLW && axiIn.wready) || fillEn) begin
      beat_ff <= 2'(beat_ff + 2'h1);
    end
  end

  // axi master: whole-line incrementing bursts only
  assign axiOut.awvalid = (state_ff == ST_FLAW);
  assign axiOut.awaddr = {bufTag_ff[flushSel_ff], LINE_OFS};
  assign axiOut.awlen = AXI_LEN_LINE;
  assign axiOut.awsize = AXI_SIZE_WORD;
  assign axiOut.awburst = AXI_BURST_INCR;
  assign axiOut.wvalid = (state_ff == ST_FLW);
  assign axiOut.wdata = bufData_ff[flushSel_ff][beat_ff];
  assign axiOut.wstrb = bufMask_ff[flushSel_ff][beat_ff]; // untouched bytes are never overwritten
  assign axiOut.wlast = (beat_ff == LAST_BEAT);
  assign axiOut.bready = (state_ff == ST_FLB);
  assign axiOut.arvalid = (state_ff == ST_RDAR);
  assign axiOut.araddr = {curTag, LINE_OFS};
  assign axiOut.arlen = AXI_LEN_LINE;
  assign axiOut.arsize = AXI_SIZE_WORD;
  assign axiOut.arburst = AXI_BURST_INCR;
  assign axiOut.rready = (state_ff == ST_RDR);

endmodule

// [rtl/adb_pkg.sv]
// constants, carrier structs and state encoding for the ahb-to-axi combining bridge
// assumes one 10 MHz clock, 32-bit ahb-lite ports and a 32-bit axi master port
package adb_pkg;
  localparam int NUM_PORTS = 4;
  localparam int NUM_BUFS = 4;
  localparam int NUM_WR_BUFS = 3;
  localparam int RD_BUF = 3;
  localparam int LINE_WORDS = 4;
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic [1:0] LAST_BEAT = 2'h3;
  localparam logic [7:0] AXI_LEN_LINE = 8'h03;
  localparam logic [2:0] AXI_SIZE_WORD = 3'h2;
  localparam logic [1:0] AXI_BURST_INCR = 2'h1;
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_HALF = 3'h1;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [3:0] LINE_OFS = 4'h0;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic [27:0] TAG_RST = 28'h000_0000;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [1:0] IDX_RST = 2'h0;

  typedef logic [27:0] adb_tag_t;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } adb_ahb_req_t;

  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } adb_ahb_rsp_t;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic [7:0] awlen;
    logic [2:0] awsize;
    logic [1:0] awburst;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wlast;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic [7:0] arlen;
    logic [2:0] arsize;
    logic [1:0] arburst;
    logic rready;
  } adb_axi_out_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rlast;
  } adb_axi_in_t;

  // gray along idle-look-read and look-flush paths
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_LOOK = 3'h1,
    ST_RDAR = 3'h3,
    ST_RDR  = 3'h2,
    ST_FLB  = 3'h6,
    ST_FLAW = 3'h5,
    ST_FLW  = 3'h7
  } adb_state_t;
endpackage
